// ===== common/psl_cfg.svh
// Purpose: timing counts and input bit positions for the
//          serial chain loader
// Assumes: system clock of 50 MHz
// Notes: each time is kept in its own unit and, except PSL_T_STATUS_MAX_US and PSL_T_CD2UM_MAX_US, turned into clock cycles here
`ifndef PSL_CFG_SVH
`define PSL_CFG_SVH

// system clock rate
`define PSL_CLK_MHZ 50
`define PSL_CLK_PERIOD_NS 20

// least low time of the error/reset line, rounded up to cycles
`define PSL_T_STATUS_MIN_US 45
`define PSL_STATUS_MIN_CYC (`PSL_T_STATUS_MIN_US * `PSL_CLK_MHZ)
// longest low time of the error/reset line when nothing extends it
`define PSL_T_STATUS_MAX_US 800
// reaction to a falling load request, longest time, rounded down
`define PSL_T_REQ_RESP_NS 500
`define PSL_REQ_RESP_CYC (`PSL_T_REQ_RESP_NS / `PSL_CLK_PERIOD_NS)
// automatic restart time-out, longest time, rounded down
`define PSL_T_RESTART_US 230
`define PSL_RESTART_CYC (`PSL_T_RESTART_US * `PSL_CLK_MHZ)
// internal oscillator start-up window, the least time is used
`define PSL_T_CD2UM_MIN_US 300
`define PSL_T_CD2UM_MAX_US 650
`define PSL_CD2UM_CYC (`PSL_T_CD2UM_MIN_US * `PSL_CLK_MHZ)
// gap before the user start-up clock is enabled: four slowest serial periods
`define PSL_CD2CU_PERIODS 4
`define PSL_SERIAL_PERIOD_MAX_NS 1000
`define PSL_CD2CU_CYC ((`PSL_CD2CU_PERIODS * `PSL_SERIAL_PERIOD_MAX_NS + `PSL_CLK_PERIOD_NS - 1) / `PSL_CLK_PERIOD_NS)
// falling serial edges needed after load-complete rises
`define PSL_INIT_EDGES 2
// power-on hold of the error/reset line and user clock initialisation cycles
`define PSL_POR_CYC 1000
`define PSL_INIT_USR_CYC 64

// bit positions of the synchronised input vector
`define PSL_IN_SCLK 0
`define PSL_IN_DATA 1
`define PSL_IN_CE_N 2
`define PSL_IN_REQ_N 3
`define PSL_IN_ERR 4
`define PSL_IN_DONE 5
`define PSL_IN_UCLK 6
`define PSL_IN_SEL 7
`define PSL_IN_AUTO 8
`define PSL_IN_W 9

`endif

// ===== common/psl_pkg.sv
// Purpose: types shared by the serial chain loader modules
// Assumes: widths of the state record fixed at 32-bit counters
// Notes: numbers live in psl_cfg.svh
package psl_pkg;

    // loader sequence
    typedef enum logic [3:0] {
        ST_POR,
        ST_PULSE,
        ST_WAIT_LINE,
        ST_LOAD,
        ST_WAIT_DONE,
        ST_INIT_EDGES,
        ST_GAP,
        ST_USR_INIT,
        ST_OSC,
        ST_USER,
        ST_FAULT
    } psl_state_e;

    // whole register state of the loader
    typedef struct packed {
        psl_state_e state;
        logic [8:0] sync1;
        logic [8:0] sync2;
        logic prev_sclk;
        logic prev_uclk;
        logic [31:0] cnt;
        logic [31:0] bits;
        logic [7:0] shift;
        logic err_oe_n;
        logic done_oe_n;
        logic chain_n;
        logic user_mode;
        logic push_valid;
        logic [7:0] push_data;
    } psl_state_s;

    // whole register state of the two-entry buffer
    typedef struct packed {
        logic head_valid;
        logic [7:0] head_data;
        logic spare_valid;
        logic [7:0] spare_data;
    } psl_buf_s;

endpackage

// ===== common/psl_stream_if.sv
// Purpose: byte stream between the loader core and its buffer
// Assumes: one clock, valid and ready handshake
// Notes: a word moves in a cycle where valid and ready are both high
`timescale 1ns/1ns
interface psl_stream_if #(parameter int unsigned WIDTH = 8);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ===== rtl/psl_buf2.sv
// Purpose: two-entry buffer between the loader and the byte consumer
// Assumes: same clock on both sides
// Notes: head and spare are flip-flops, so all outputs come from registers
`timescale 1ns/1ns
module psl_buf2 import psl_pkg::*; (
    input wire logic i_clock,
    input wire logic i_rst_n,
    psl_stream_if.snk up,
    output logic [7:0] o_data,
    output logic o_valid,
    input wire logic i_ready
);
    psl_buf_s q; // registered state
    psl_buf_s d; // next state

    // fill order: head first, spare only while head is stalled
    always_comb begin
        logic pop;
        pop = q.head_valid & i_ready;
        d = q;
        if (pop) begin
            d.head_valid = q.spare_valid;
            d.head_data = q.spare_data;
            d.spare_valid = 1'b0;
        end
        if (up.valid & ~q.spare_valid) begin
            // new word lands in head when it is or becomes free
            if (~d.head_valid) begin
                d.head_valid = 1'b1;
                d.head_data = up.data;
            end else begin
                d.spare_valid = 1'b1;
                d.spare_data = up.data;
            end
        end
    end

    // one register stage holds the whole buffer
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ready drops only once both entries hold data: honest full
    assign up.ready = ~q.spare_valid;
    assign o_data = q.head_data;
    assign o_valid = q.head_valid;
endmodule // psl_buf2

// ===== rtl/psl_loader.sv
// Purpose: passive serial configuration receiver for one device of a chain
// Assumes: serial clock and all pins arrive asynchronously to i_clock and are
//          sampled by it; the serial clock is well below half of i_clock
// Notes: open-drain lines use an enable that is low while the pin is pulled
`timescale 1ns/1ns
`include "psl_cfg.svh"
module psl_loader import psl_pkg::*; #(
    parameter int unsigned IMAGE_BITS = 1024,
    parameter int unsigned POR_CYC = `PSL_POR_CYC,
    parameter int unsigned RESTART_CYC = `PSL_RESTART_CYC,
    parameter int unsigned OSC_CYC = `PSL_CD2UM_CYC,
    parameter int unsigned GAP_CYC = `PSL_CD2CU_CYC,
    parameter int unsigned INIT_USR_CYC = `PSL_INIT_USR_CYC
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_serial_load_clock,
    input wire logic i_serial_data,
    input wire logic i_chip_enable_n,
    input wire logic i_load_request_n,
    input wire logic i_error_line,
    input wire logic i_load_done_line,
    input wire logic i_user_startup_clock,
    input wire logic i_scheme_select,
    input wire logic i_auto_restart,
    input wire logic i_byte_ready,
    output logic o_error_out,
    output logic o_error_oe_n,
    output logic o_load_done_out,
    output logic o_load_done_oe_n,
    output logic o_chain_enable_n,
    output logic o_user_mode,
    output logic [7:0] o_byte_data,
    output logic o_byte_valid
);
    // parameters the sequencing cannot serve are refused here
    if (IMAGE_BITS < 8 || IMAGE_BITS % 8 != 0) begin : g_bad_image
        $error("image length must be a whole number of bytes");
    end
    if (RESTART_CYC < `PSL_STATUS_MIN_CYC) begin : g_bad_restart
        $error("restart time-out shorter than least error pulse");
    end
    if (POR_CYC == 0 || OSC_CYC == 0 || GAP_CYC == 0 || INIT_USR_CYC == 0) begin : g_bad_count
        $error("start-up counts must be at least one");
    end

    psl_state_s q; // registered state
    psl_state_s d; // next state
    psl_stream_if #(.WIDTH(8)) push (); // loader to buffer

    logic [`PSL_IN_W-1:0] pins; // raw asynchronous inputs
    logic [`PSL_IN_W-1:0] s; // inputs after two flops
    logic sclk_rise; // serial clock rising edge seen
    logic sclk_fall; // serial clock falling edge seen
    logic uclk_rise; // user start-up clock rising edge seen
    logic byte_end; // this sample completes a byte
    logic image_end; // this sample completes the image

    // gather the pins; none is read before the second flop
    assign pins[`PSL_IN_SCLK] = i_serial_load_clock;
    assign pins[`PSL_IN_DATA] = i_serial_data;
    assign pins[`PSL_IN_CE_N] = i_chip_enable_n;
    assign pins[`PSL_IN_REQ_N] = i_load_request_n;
    assign pins[`PSL_IN_ERR] = i_error_line;
    assign pins[`PSL_IN_DONE] = i_load_done_line;
    assign pins[`PSL_IN_UCLK] = i_user_startup_clock;
    assign pins[`PSL_IN_SEL] = i_scheme_select;
    assign pins[`PSL_IN_AUTO] = i_auto_restart;
    assign s = q.sync2;

    // edges are found against the previous synchronised sample
    assign sclk_rise = s[`PSL_IN_SCLK] & ~q.prev_sclk;
    assign sclk_fall = ~s[`PSL_IN_SCLK] & q.prev_sclk;
    assign uclk_rise = s[`PSL_IN_UCLK] & ~q.prev_uclk;
    assign byte_end = (q.bits[2:0] == 3'h7);
    assign image_end = (q.bits + 32'h1 == IMAGE_BITS);

    // next-state logic of the whole sequence
    always_comb begin
        d = q;
        d.sync1 = pins;
        d.sync2 = q.sync1;
        d.prev_sclk = s[`PSL_IN_SCLK];
        d.prev_uclk = s[`PSL_IN_UCLK];
        d.push_valid = 1'b0;
        d.cnt = q.cnt + 32'h1;
        case (q.state)
            ST_POR: begin
                // error line held low through the power-on delay
                d.err_oe_n = 1'b0;
                d.done_oe_n = 1'b0;
                if (q.cnt >= POR_CYC - 1) begin
                    d.state = ST_PULSE;
                    d.cnt = '0;
                end
            end
            ST_PULSE: begin
                // least width first, then wait for the request to rise;
                // a host that holds the request low stretches the pulse
                d.err_oe_n = 1'b0;
                d.done_oe_n = 1'b0;
                if (s[`PSL_IN_REQ_N] && q.cnt >= `PSL_STATUS_MIN_CYC - 1) begin
                    d.err_oe_n = 1'b1;
                    d.state = ST_WAIT_LINE;
                end
            end
            ST_WAIT_LINE: begin
                // another device may still hold the shared line low
                d.bits = '0;
                d.chain_n = 1'b1;
                if (s[`PSL_IN_ERR]) begin
                    d.state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (!s[`PSL_IN_ERR]) begin
                    // a neighbour flagged an error: our load is void too
                    d.state = ST_WAIT_LINE;
                end else if (!s[`PSL_IN_CE_N] && sclk_rise) begin
                    // first bit ends up in bit 0 of the byte
                    d.shift = {s[`PSL_IN_DATA], q.shift[7:1]};
                    d.bits = q.bits + 32'h1;
                    if (byte_end && !push.ready) begin
                        // consumer stalled with both entries full: lost byte
                        d.state = ST_FAULT;
                        d.err_oe_n = 1'b0;
                        d.cnt = '0;
                    end else begin
                        if (byte_end) begin
                            d.push_valid = 1'b1;
                            d.push_data = {s[`PSL_IN_DATA], q.shift[7:1]};
                        end
                        if (image_end) begin
                            // release the wired done line, enable the next device;
                            // its two-flop sampler sees this in three clocks
                            d.done_oe_n = 1'b1;
                            d.chain_n = 1'b0;
                            d.state = ST_WAIT_DONE;
                        end
                    end
                end
            end
            ST_WAIT_DONE: begin
                // every device waits for the wired line to go high
                if (!s[`PSL_IN_ERR]) begin
                    d.done_oe_n = 1'b0;
                    d.state = ST_WAIT_LINE;
                end else if (s[`PSL_IN_DONE]) begin
                    d.state = ST_INIT_EDGES;
                    d.cnt = '0;
                end
            end
            ST_INIT_EDGES: begin
                // count falling serial edges rather than cycles
                d.cnt = q.cnt;
                if (sclk_fall) begin
                    d.cnt = q.cnt + 32'h1;
                    if (q.cnt == `PSL_INIT_EDGES - 1) begin
                        d.cnt = '0;
                        d.state = s[`PSL_IN_SEL] ? ST_GAP : ST_OSC;
                    end
                end
            end
            ST_GAP: begin
                // user clock stays ignored until the gap has passed
                if (q.cnt >= GAP_CYC - 1) begin
                    d.cnt = '0;
                    d.state = ST_USR_INIT;
                end
            end
            ST_USR_INIT: begin
                d.cnt = q.cnt;
                if (uclk_rise) begin
                    d.cnt = q.cnt + 32'h1;
                    if (q.cnt >= INIT_USR_CYC - 1) begin
                        d.state = ST_USER;
                        d.user_mode = 1'b1;
                    end
                end
            end
            ST_OSC: begin
                // internal oscillator: enter user mode at the least time
                if (q.cnt >= OSC_CYC - 1) begin
                    d.state = ST_USER;
                    d.user_mode = 1'b1;
                end
            end
            ST_USER: begin
                d.cnt = q.cnt;
            end
            ST_FAULT: begin
                // without auto restart the line stays low until a request
                d.err_oe_n = 1'b0;
                d.done_oe_n = 1'b0;
                d.chain_n = 1'b1;
                if (s[`PSL_IN_AUTO] && q.cnt >= RESTART_CYC - 1) begin
                    d.err_oe_n = 1'b1;
                    d.state = ST_WAIT_LINE;
                end
            end
            default: begin
                d.state = ST_PULSE;
                d.cnt = '0;
            end
        endcase
        // a falling request restarts everything; three clocks to react
        if (!s[`PSL_IN_REQ_N] && q.state != ST_POR && q.state != ST_PULSE) begin
            d.state = ST_PULSE;
            d.cnt = '0;
            d.err_oe_n = 1'b0;
            d.done_oe_n = 1'b0;
            d.chain_n = 1'b1;
            d.user_mode = 1'b0;
            d.bits = '0;
        end
    end

    // single register stage for the whole record
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '{state: ST_POR, sync1: '0, sync2: '0, prev_sclk: 1'b0,
                   prev_uclk: 1'b0, cnt: '0, bits: '0, shift: '0,
                   err_oe_n: 1'b0, done_oe_n: 1'b0, chain_n: 1'b1,
                   user_mode: 1'b0, push_valid: 1'b0, push_data: '0};
        end else begin
            q <= d;
        end
    end

    // pushes are at least eight serial periods apart, so ready seen one
    // clock earlier still holds when the word arrives
    assign push.valid = q.push_valid;
    assign push.data = q.push_data;

    psl_buf2 u_buf (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .up(push),
        .o_data(o_byte_data),
        .o_valid(o_byte_valid),
        .i_ready(i_byte_ready)
    );

    // open-drain lines only ever pull low; the level bit is q.shift[0] masked to a constant 0
    assign o_error_out = q.shift[0] & 1'b0;
    assign o_error_oe_n = q.err_oe_n;
    assign o_load_done_out = q.shift[0] & 1'b0;
    assign o_load_done_oe_n = q.done_oe_n;
    assign o_chain_enable_n = q.chain_n;
    assign o_user_mode = q.user_mode;
endmodule // psl_loader

// ===== tb/psl_loader_properties.sv
// Purpose: pin timing checks for the serial chain loader
// Assumes: one clock domain; long windows come from parameters
// Notes: counters stand in for windows too long for delays
`timescale 1ns/1ns
module psl_loader_props import psl_pkg::*; #(
    parameter int unsigned POR_CYC = 10,
    parameter int unsigned OSC_CYC = 20,
    parameter int unsigned GAP_CYC = 5
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_chip_enable_n,
    input wire logic i_load_request_n,
    input wire logic i_load_done_line,
    input wire logic i_scheme_select,
    input wire logic i_byte_ready,
    input wire logic o_error_oe_n,
    input wire logic o_load_done_oe_n,
    input wire logic o_chain_enable_n,
    input wire logic o_user_mode,
    input wire logic [7:0] o_byte_data,
    input wire logic o_byte_valid
);
    localparam int unsigned STATUS_MIN = 2250; // 45 us
    localparam int unsigned STATUS_MAX = 40000; // 800 us
    logic [31:0] up_q; // cycles since reset release
    logic [31:0] low_q; // length of the current low pulse
    logic [31:0] arm_q; // low cycles since the request rose
    logic [31:0] dhi_q; // cycles the done line has been high
    logic arm_q_f; // request seen, line not yet released
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    // arming keeps a fault without restart out of the release window
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            up_q <= '0;
            low_q <= '0;
            arm_q <= '0;
            dhi_q <= '0;
            arm_q_f <= 1'b0;
        end else begin
            up_q <= up_q + 32'h1;
            low_q <= o_error_oe_n ? '0 : low_q + 32'h1;
            arm_q_f <= !i_load_request_n || (arm_q_f && !o_error_oe_n);
            arm_q <= (arm_q_f && i_load_request_n && !o_error_oe_n) ? arm_q + 32'h1 : '0;
            dhi_q <= i_load_done_line ? dhi_q + 32'h1 : '0;
        end
    end
    req_answer_a: assert property ($fell(i_load_request_n) |-> ##[0:24] (!o_error_oe_n && !o_load_done_oe_n))
        else $error("request not answered in time");
    user_drop_a: assert property ($fell(i_load_request_n) |-> ##[0:24] !o_user_mode)
        else $error("user mode kept after request");
    por_hold_a: assert property ((up_q < POR_CYC) |-> !o_error_oe_n)
        else $error("error line released during power-on");
    pulse_min_a: assert property ($rose(o_error_oe_n) |-> (low_q >= STATUS_MIN))
        else $error("error pulse too short");
    release_max_a: assert property (arm_q <= STATUS_MAX)
        else $error("error line held too long");
    chain_on_done_a: assert property ($rose(o_load_done_oe_n) |-> !o_chain_enable_n)
        else $error("chain not enabled at image end");
    ce_idle_a: assert property (i_chip_enable_n [*4] |-> o_chain_enable_n)
        else $error("chain enabled while not selected");
    start_delay_a: assert property ($rose(o_user_mode) |-> dhi_q >= (i_scheme_select ? GAP_CYC : OSC_CYC))
        else $error("user mode too early");
    user_done_a: assert property (o_user_mode |-> (o_load_done_oe_n && i_load_done_line))
        else $error("user mode without done line");
    byte_hold_a: assert property (o_byte_valid && !i_byte_ready |=> o_byte_valid && $stable(o_byte_data))
        else $error("byte lost while stalled");
    cover property ($rose(o_user_mode) && !i_scheme_select);
    cover property ($rose(o_user_mode) && i_scheme_select);
    cover property (o_byte_valid && !i_byte_ready);
endmodule // psl_loader_props

bind psl_loader psl_loader_props #(.POR_CYC(POR_CYC), .OSC_CYC(OSC_CYC), .GAP_CYC(GAP_CYC)) u_props (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_chip_enable_n(i_chip_enable_n),
    .i_load_request_n(i_load_request_n), .i_load_done_line(i_load_done_line),
    .i_scheme_select(i_scheme_select), .i_byte_ready(i_byte_ready), .o_error_oe_n(o_error_oe_n),
    .o_load_done_oe_n(o_load_done_oe_n), .o_chain_enable_n(o_chain_enable_n), .o_user_mode(o_user_mode),
    .o_byte_data(o_byte_data), .o_byte_valid(o_byte_valid));

// ===== tb/psl_host_model.sv
// Purpose: host that feeds the serial image and pulses the request
// Assumes: 160 ns serial period; lines resolved by the bench
// Notes: serial clock stands low between frames
`timescale 1ns/1ns
module psl_host_model (
    input wire logic i_error_line,
    output logic o_serial_load_clock,
    output logic o_serial_data,
    output logic o_load_request_n
);
    // fixed idle levels, never floating
    initial begin
        o_serial_load_clock = 1'b0;
        o_serial_data = 1'b0;
        o_load_request_n = 1'b1;
    end
    // low pulse longer than the least allowed
    task automatic request_pulse;
        o_load_request_n = 1'b0;
        #600;
        o_load_request_n = 1'b1;
    endtask
    // no clock until the error line has been up a while; the gap after the
    // request follows the error pulse, which keeps its full least width in the bench
    task automatic wait_ready;
        wait (i_error_line === 1'b1);
        #2000;
    endtask
    // one byte; data moves only while the clock is low; 160 ns period
    task automatic send_byte(input logic [7:0] b);
        #7;
        for (int i = 0; i < 8; i++) begin
            o_serial_data = b[i];
            #80 o_serial_load_clock = 1'b1;
            #80 o_serial_load_clock = 1'b0;
        end
        o_serial_data = ~b[7]; // stale bit not left on the line
    endtask
    // falling edges that let initialisation begin
    task automatic falls(input int n);
        for (int i = 0; i < n; i++) begin
            #80 o_serial_load_clock = 1'b1;
            #80 o_serial_load_clock = 1'b0;
        end
    endtask
endmodule // psl_host_model

// ===== tb/testbench.sv
// Purpose: self-checking bench for the serial chain loader
// Assumes: host model drives serial pins and the request, bench the rest
// Notes: long counts shortened through parameters
`timescale 1ns/1ns
module testbench import psl_pkg::*; ;
    localparam int RESTART = 2250; // shortest legal restart time-out
    localparam logic [7:0] IMG [4] = '{8'h01, 8'h80, 8'h5a, 8'hc3}; // bit order shows
    logic clock, rst_n, ce_n, ext_done_n, uclk, uclk_en, sel, ready, auto_rs;
    wire sclk, sdata, req_n, err_oe_n, done_oe_n, chain_n, user_mode, byte_valid, err_out, done_out;
    wire [7:0] byte_data;
    // open-drain lines: the driven level wins while enabled, else the pull-up
    wire err_line = err_oe_n | err_out; // only this device pulls it
    wire done_line = (done_oe_n | done_out) & ext_done_n; // another party may hold it low
    logic [7:0] got [$]; // bytes taken by the consumer
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    psl_host_model u_host (.i_error_line(err_line), .o_serial_load_clock(sclk), .o_serial_data(sdata),
        .o_load_request_n(req_n));
    // user clock initialisation keeps its full default count
    psl_loader #(.IMAGE_BITS(32), .POR_CYC(10), .RESTART_CYC(RESTART), .OSC_CYC(20), .GAP_CYC(5)) u_dut (
        .i_clock(clock), .i_rst_n(rst_n), .i_serial_load_clock(sclk), .i_serial_data(sdata),
        .i_chip_enable_n(ce_n), .i_load_request_n(req_n), .i_error_line(err_line),
        .i_load_done_line(done_line), .i_user_startup_clock(uclk), .i_scheme_select(sel),
        .i_auto_restart(auto_rs), .i_byte_ready(ready), .o_error_out(err_out), .o_error_oe_n(err_oe_n),
        .o_load_done_out(done_out), .o_load_done_oe_n(done_oe_n), .o_chain_enable_n(chain_n),
        .o_user_mode(user_mode), .o_byte_data(byte_data), .o_byte_valid(byte_valid));
    // 50 MHz system clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // user start-up clock, stands still unless enabled
    initial begin
        uclk = 1'b0;
        #3;
        forever #50 uclk = uclk_en ? ~uclk : uclk;
    end
    // consumer and hang limit
    always @(posedge clock) begin
        cyc++;
        if (byte_valid === 1'b1 && ready === 1'b1) got.push_back(byte_data);
        if (cyc == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // bounded wait for the error line release
    task automatic wait_err(input int lim, output int n);
        n = 0;
        while (err_oe_n !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
    endtask
    task automatic complete_run;
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic t_power;
        int n;
        tick(2);
        check(err_oe_n, 1'b0);
        check(done_oe_n, 1'b0);
        check({err_out, done_out}, 2'h0);
        wait_err(3000, n);
        check(n >= 2250, 1'b1);
        check(n < 3000, 1'b1);
        u_host.wait_ready();
    endtask
    // whole image sent while not selected
    task automatic t_ce_idle;
        for (int i = 0; i < 4; i++) u_host.send_byte(IMG[i]);
        tick(8);
        check(byte_valid, 1'b0);
        check(chain_n, 1'b1);
        // a host counting bits would call this load failed
        check(done_oe_n, 1'b0);
    endtask
    // consumer stalls for two bytes, then drains
    task automatic t_load;
        tick(1);
        ce_n = 1'b0;
        ready = 1'b0;
        ext_done_n = 1'b0;
        u_host.send_byte(IMG[0]);
        u_host.send_byte(IMG[1]);
        tick(8);
        check(byte_valid, 1'b1);
        check(byte_data, IMG[0]);
        ready = 1'b1;
        u_host.send_byte(IMG[2]);
        tick(8);
        check(chain_n, 1'b1);
        check(done_oe_n, 1'b0);
        u_host.send_byte(IMG[3]);
        tick(8);
        check(got.size(), 4);
        for (int i = 0; i < 4; i++) check(got[i], IMG[i]);
        check(done_oe_n, 1'b1);
        check(chain_n, 1'b0);
    endtask
    // done line held low elsewhere, then released
    task automatic t_start;
        u_host.falls(2);
        tick(40);
        check(user_mode, 1'b0);
        ext_done_n = 1'b1;
        tick(4);
        u_host.falls(2);
        tick(4);
        check(user_mode, 1'b0);
        tick(40);
        check(user_mode, 1'b1);
    endtask
    task automatic t_reconf;
        int n = 0;
        fork
            u_host.request_pulse();
            while (err_oe_n !== 1'b0 && n < 40) begin
                tick(1);
                n++;
            end
        join
        check(n <= 25, 1'b1);
        check(done_oe_n, 1'b0);
        check(user_mode, 1'b0);
        wait_err(3000, n);
        check(n < 3000, 1'b1);
        u_host.wait_ready();
    endtask
    // user start-up clock held still, then run
    task automatic t_uclk;
        sel = 1'b1;
        t_reconf();
        for (int i = 0; i < 4; i++) u_host.send_byte(IMG[i]);
        u_host.falls(2);
        tick(30);
        check(user_mode, 1'b0);
        uclk_en = 1'b1;
        tick(300);
        check(user_mode, 1'b0);
        tick(40);
        check(user_mode, 1'b1);
        uclk_en = 1'b0;
        sel = 1'b0;
    endtask
    // third byte meets a full buffer
    task automatic t_fault;
        int n;
        t_reconf();
        tick(1);
        ready = 1'b0;
        for (int i = 0; i < 3; i++) u_host.send_byte(IMG[i]);
        tick(6);
        check(err_oe_n, 1'b0);
        ready = 1'b1;
        wait_err(RESTART + 40, n);
        check(n < RESTART + 40, 1'b1);
        // second overrun with automatic restart off: the line must stay low
        auto_rs = 1'b0;
        u_host.wait_ready();
        tick(1);
        ready = 1'b0;
        for (int i = 0; i < 3; i++) u_host.send_byte(IMG[i]);
        tick(RESTART + 40);
        check(err_oe_n, 1'b0);
        ready = 1'b1;
    endtask
    // reset for three cycles, then the scenarios
    initial begin
        rst_n = 1'b0;
        ce_n = 1'b1;
        ext_done_n = 1'b1;
        uclk_en = 1'b0;
        sel = 1'b0;
        ready = 1'b1;
        auto_rs = 1'b1;
        tick(3);
        rst_n = 1'b1;
        t_power();
        t_ce_idle();
        t_load();
        t_start();
        t_uclk();
        t_fault();
        complete_run();
    end
endmodule // testbench
